// File: logic/motor_ctrl_defines.svh
// Offsets, field positions, reset values and timing counts of the block.
`ifndef MOTOR_CTRL_DEFINES_SVH
`define MOTOR_CTRL_DEFINES_SVH
`define CLK_MHZ          125
`define CL_DEGLITCH_NS   500
`define CL_DEGLITCH_CYC  ((`CL_DEGLITCH_NS * `CLK_MHZ + 999) / 1000)
`define CL_OFF_NS        24000
`define CL_OFF_CYC       ((`CL_OFF_NS * `CLK_MHZ + 999) / 1000)
`define FRAME_LAST       5'h0F
`define FRAME_DONE       5'h10
`define ADR_NORMAL_TX    8'h00
`define ADR_FAULT_FRAME_A_TX      8'h04
`define ADR_NORMAL_RX    8'h08
`define ADR_CONFIG_RX    8'h0C
`define ADR_STATUS       8'h10
`define NB_CFG_SEL       0
`define NB_FAULT_FRAME_A_REQ      1
`define NB_DIR_A         2
`define NB_DIR_B         3
`define NB_DIR_C         4
`define NB_GP_HIGH_1     5
`define NB_GP_HIGH_2     6
`define NB_GP_LOW_1      7
`define NB_GP_LOW_2      8
`define CB_C_MODE        13
`define NORMAL_RESET     16'h0000
`define CONFIG_RESET     16'h0000
`define TX_RESET         16'h0000
`define BR_FWD           4'h9
`define BR_REV           4'h6
`define BR_BRAKE         4'h5
`define BR_OFF           4'h0
`endif

// File: logic/motor_ctrl_pkg.sv
// Types shared by the motor control files.
package motor_ctrl_pkg;
  typedef enum logic {stepper_mode = 1'b0, dc_mode = 1'b1} drv_c_mode_t;
  typedef logic [15:0] frame_t;
endpackage

// File: logic/cl_filter.sv
// Current-limit deglitch filter followed by a bridge off-timer.
`timescale 1ns/1ns
module cl_filter #(
  parameter int DEG_CYC = 63,
  parameter int OFF_CYC = 3000
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic detect,
  output logic      trip
);
  logic [15:0] deg;
  logic [15:0] off;
  logic [15:0] run;
  logic        confirm;

  // A detection counts only once it has stood for the whole filter time.
  assign confirm = detect && !trip && (deg == 16'(DEG_CYC - 1));

  // Glitch counter restarts whenever the detection drops.
  always_ff @(posedge clk)
  begin
    if (!rst_n || trip || !detect)
      deg <= 16'h0000;
    else if (!confirm)
      deg <= deg + 16'h0001;
  end

  // The off-timer keeps the bridge dark long enough to cap average duty.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      off  <= 16'h0000;
      trip <= 1'b0;
    end
    else if (confirm)
    begin
      off  <= 16'(OFF_CYC - 1);
      trip <= 1'b1;
    end
    else if (off != 16'h0000)
      off <= off - 16'h0001;
    else
      trip <= 1'b0;
  end

  // Run length of the raw detection, read only by the checks below.
  always_ff @(posedge clk)
  begin
    if (!rst_n || !detect)
      run <= 16'h0000;
    else if (run != 16'hFFFF)
      run <= run + 16'h0001;
  end

  property p_deglitch;
    @(posedge clk) disable iff (!rst_n)
      $rose(trip) |-> $past(detect) && ($past(run) >= 16'(DEG_CYC - 1));
  endproperty
  a_deglitch: assert property (p_deglitch)
    else $error("Trip came before the detection stood the filter time.");

  property p_off_hold;
    @(posedge clk) disable iff (!rst_n)
      $rose(trip) |=> trip [*8];
  endproperty
  a_off_hold: assert property (p_off_hold)
    else $error("Off-timer released the bridge too early.");
endmodule // cl_filter

// File: logic/motor_serial_ctrl.sv
// Serial control port, register file and driver control of three drivers.
//
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "motor_ctrl_defines.svh"
// What this block does
// - Sixteenth rising edge loads the target register.
// - Each rising edge presents next output bit.
// - Chip enable high reloads normal or fault_frame_a data.
// - Chip enable low shifts both registers together.
// - Drivers A and B follow their PWM.
// - Driver C phases follow their PWM inputs.
// - Driver C high sides: motor or switch.
// - Config bit 13 picks stepper or DC.
// - Over-limit supply suppresses all stepper outputs.
// - Spare transistors serve as general switches.
// - Low PWM input brakes the driver, both low sides on.
// - Direction reversal applies at once, braking.
// - Deglitched current limit starts an off-timer.
// - Thermal trip switches the driver off.
// - Frame bit 0 selects config or normal.
// - Frames travel most significant bit first.
// - Reset restores defaults, parks outputs, floats data.
module motor_serial_ctrl #(
  parameter int DEG_CYC = `CL_DEGLITCH_CYC,
  parameter int OFF_CYC = `CL_OFF_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack,
  input  wire logic        sclk,
  input  wire logic        ce_n,
  input  wire logic        mosi,
  output logic             miso_o,
  output logic             miso_oe,
  input  wire logic        drv_a_pwm_in,
  input  wire logic        drv_b_pwm_in,
  input  wire logic        drv_c_pwm_first,
  input  wire logic        drv_c_pwm_second,
  input  wire logic [2:0]  cl_high,
  input  wire logic [2:0]  cl_low,
  input  wire logic [2:0]  therm_trip,
  input  wire logic        supply_over_limit,
  output logic      [3:0]  drv_a_outputs,
  output logic      [3:0]  drv_b_outputs,
  output logic             drv_c_out_first,
  output logic             drv_c_out_second,
  output logic      [1:0]  step_phase_a,
  output logic      [1:0]  step_phase_b,
  output logic      [1:0]  gp_low_switch
);
  localparam int IN_W = 17;

  logic [IN_W-1:0]             pin_s1;
  logic [IN_W-1:0]             pin_s2;
  logic                        sclk_d;
  logic                        sclk_s;
  logic                        ce_s;
  logic                        mosi_s;
  logic                        pwm_a;
  logic                        pwm_b;
  logic                        pwm_c1;
  logic                        pwm_c2;
  logic [2:0]                  clh_s;
  logic [2:0]                  cll_s;
  logic [2:0]                  therm_s;
  logic                        ovr_s;
  logic                        rise;
  logic [4:0]                  bit_cnt;
  motor_ctrl_pkg::frame_t      in_shift;
  motor_ctrl_pkg::frame_t      out_shift;
  motor_ctrl_pkg::frame_t      frame_word;
  motor_ctrl_pkg::frame_t      normal_reg;
  motor_ctrl_pkg::frame_t      config_reg;
  motor_ctrl_pkg::frame_t      normal_tx;
  motor_ctrl_pkg::frame_t      fault_frame_a_tx;
  logic                        fault_frame_a_sel;
  logic                        frame_end;
  logic [5:0]                  cl_trip;
  logic [2:0]                  fault;
  motor_ctrl_pkg::drv_c_mode_t c_mode;
  logic [3:0]                  bridge_c;
  logic                        wb_req;
  logic [31:0]                 next_dat;

  // Byte-lane merge of a 16-bit register, used by both writable words.
  function automatic motor_ctrl_pkg::frame_t merge16(
    input motor_ctrl_pkg::frame_t old,
    input logic [31:0]            data,
    input logic [3:0]             sel
  );
    merge16 = {sel[1] ? data[15:8] : old[15:8],
               sel[0] ? data[7:0]  : old[7:0]};
  endfunction

  // H-bridge pattern {high1, low1, high2, low2}; shared by all drivers.
  function automatic logic [3:0] bridge(
    input logic pwm,
    input logic dir,
    input logic off
  );
    if (off)
      bridge = `BR_OFF;
    else if (!pwm)
      bridge = `BR_BRAKE;
    else
      bridge = dir ? `BR_REV : `BR_FWD;
  endfunction

  // Every pin from the host or the power stage passes two flip-flops.
  always_ff @(posedge clk)
  begin
    pin_s1 <= {supply_over_limit, therm_trip, cl_low, cl_high,
               drv_c_pwm_second, drv_c_pwm_first, drv_b_pwm_in,
               drv_a_pwm_in, mosi, ce_n, sclk};
    pin_s2 <= pin_s1;
    sclk_d <= pin_s2[0];
  end

  assign sclk_s  = pin_s2[0];
  assign ce_s    = pin_s2[1];
  assign mosi_s  = pin_s2[2];
  assign pwm_a   = pin_s2[3];
  assign pwm_b   = pin_s2[4];
  assign pwm_c1  = pin_s2[5];
  assign pwm_c2  = pin_s2[6];
  assign clh_s   = pin_s2[9:7];
  assign cll_s   = pin_s2[12:10];
  assign therm_s = pin_s2[15:13];
  assign ovr_s   = pin_s2[16];
  assign rise    = sclk_s && !sclk_d;

  // The word as it stands after the current edge, last bit from the pin.
  assign frame_word = {in_shift[14:0], mosi_s};
  assign frame_end  = rise && !ce_s && (bit_cnt == `FRAME_LAST);
  assign c_mode     = motor_ctrl_pkg::drv_c_mode_t'(config_reg[`CB_C_MODE]);

  // Edge counter; edges past the sixteenth are ignored until the frame
  // closes, so a long frame cannot load twice.
  always_ff @(posedge clk)
  begin
    if (!rst_n || ce_s)
      bit_cnt <= 5'h00;
    else if (rise && bit_cnt != `FRAME_DONE)
      bit_cnt <= bit_cnt + 5'h01;
  end

  // Input shift register, first bit received lands at the top.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      in_shift <= 16'h0000;
    else if (rise && !ce_s)
      in_shift <= frame_word;
  end

  // Output shift register: reloaded between frames, shifted within.
  // Extra edges between frames simply reload again; the host is expected
  // to give only one so status captured inside the device stays coherent.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      out_shift <= `TX_RESET;
    else if (rise && ce_s)
      out_shift <= fault_frame_a_sel ? fault_frame_a_tx : normal_tx;
    else if (rise)
      out_shift <= {out_shift[14:0], 1'b0};
  end

  assign miso_o = out_shift[15];

  // Data pin floats during reset and is driven from then on.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      miso_oe <= 1'b0;
    else
      miso_oe <= 1'b1;
  end

  // Only the sixteenth edge commits; a frame cut short leaves no trace.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      normal_reg <= `NORMAL_RESET;
      config_reg <= `CONFIG_RESET;
      fault_frame_a_sel   <= 1'b0;
    end
    else if (frame_end)
    begin
      if (frame_word[`NB_CFG_SEL])
        config_reg <= frame_word;
      else
      begin
        normal_reg <= frame_word;
        fault_frame_a_sel   <= frame_word[`NB_FAULT_FRAME_A_REQ];
      end
    end
  end

  // One filter per current-limit detector, high sides then low sides.
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_cl
      cl_filter #(
        .DEG_CYC (DEG_CYC),
        .OFF_CYC (OFF_CYC)
      ) u_cl (
        .clk    (clk),
        .rst_n  (rst_n),
        .detect (gi < 3 ? clh_s[gi % 3] : cll_s[gi % 3]),
        .trip   (cl_trip[gi])
      );
    end
  endgenerate

  assign fault    = cl_trip[2:0] | cl_trip[5:3] | therm_s;
  assign bridge_c = bridge(pwm_c1, normal_reg[`NB_DIR_C], fault[2]);

  // Drivers A and B; direction is read live, so a reversal under current
  // acts on the next clock and brakes the motor.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      drv_a_outputs <= `BR_BRAKE;
      drv_b_outputs <= `BR_BRAKE;
    end
    else
    begin
      drv_a_outputs <= bridge(pwm_a, normal_reg[`NB_DIR_A], fault[0]);
      drv_b_outputs <= bridge(pwm_b, normal_reg[`NB_DIR_B], fault[1]);
    end
  end

  // Driver C: DC bridge with spare low switches, or stepper with spare
  // high switches. Counterphase is the complement of the phase pin.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      drv_c_out_first  <= 1'b0;
      drv_c_out_second <= 1'b0;
      step_phase_a     <= 2'b00;
      step_phase_b     <= 2'b00;
      gp_low_switch    <= 2'b00;
    end
    else if (c_mode == motor_ctrl_pkg::dc_mode)
    begin
      drv_c_out_first  <= bridge_c[3];
      drv_c_out_second <= bridge_c[1];
      step_phase_a     <= {bridge_c[2], bridge_c[0]};
      step_phase_b     <= 2'b00;
      gp_low_switch    <= {normal_reg[`NB_GP_LOW_2],
                           normal_reg[`NB_GP_LOW_1]} & {2{!fault[2]}};
    end
    else
    begin
      drv_c_out_first  <= normal_reg[`NB_GP_HIGH_1] && !fault[2];
      drv_c_out_second <= normal_reg[`NB_GP_HIGH_2] && !fault[2];
      gp_low_switch    <= 2'b00;
      if (ovr_s || fault[2])
      begin
        step_phase_a <= 2'b00;
        step_phase_b <= 2'b00;
      end
      else
      begin
        step_phase_a <= {pwm_c1, !pwm_c1};
        step_phase_b <= {pwm_c2, !pwm_c2};
      end
    end
  end

  // Wishbone slave: one wait state, ack drops the cycle after it rose.
  assign wb_req = wb_cyc && wb_stb && !wb_ack;

  always_comb
  begin
    case (wb_adr)
      `ADR_NORMAL_TX: next_dat = {16'h0000, normal_tx};
      `ADR_FAULT_FRAME_A_TX:   next_dat = {16'h0000, fault_frame_a_tx};
      `ADR_NORMAL_RX: next_dat = {16'h0000, normal_reg};
      `ADR_CONFIG_RX: next_dat = {16'h0000, config_reg};
      `ADR_STATUS:    next_dat = {22'h00_0000, c_mode, ovr_s, therm_s,
                                  fault, fault_frame_a_sel, bit_cnt == 5'h00};
      default:        next_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wb_ack   <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack   <= wb_req;
      wb_dat_o <= (wb_req && !wb_we) ? next_dat : 32'h0000_0000;
    end
  end

  // Software supplies the words the host will read back.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      normal_tx <= `TX_RESET;
      fault_frame_a_tx   <= `TX_RESET;
    end
    else if (wb_req && wb_we)
    begin
      if (wb_adr == `ADR_NORMAL_TX)
        normal_tx <= merge16(normal_tx, wb_dat_i, wb_sel);
      if (wb_adr == `ADR_FAULT_FRAME_A_TX)
        fault_frame_a_tx <= merge16(fault_frame_a_tx, wb_dat_i, wb_sel);
    end
  end

  property p_load_cfg;
    @(posedge clk) disable iff (!rst_n)
      (frame_end && mosi_s) |=> config_reg == $past(frame_word);
  endproperty
  a_load_cfg: assert property (p_load_cfg)
    else $error("Config frame not loaded on the sixteenth edge.");

  property p_load_norm;
    @(posedge clk) disable iff (!rst_n)
      (frame_end && !mosi_s) |=> normal_reg == $past(frame_word)
                                 && $stable(config_reg);
  endproperty
  a_load_norm: assert property (p_load_norm)
    else $error("Normal frame went to the wrong register.");

  property p_no_short;
    @(posedge clk) disable iff (!rst_n)
      !frame_end |=> $stable(normal_reg) && $stable(config_reg);
  endproperty
  a_no_short: assert property (p_no_short)
    else $error("Register changed outside a completed frame.");

  property p_shift;
    @(posedge clk) disable iff (!rst_n)
      (rise && !ce_s) |=> miso_o == $past(out_shift[14]);
  endproperty
  a_shift: assert property (p_shift)
    else $error("Data pin did not advance on a clock edge.");

  property p_reload;
    @(posedge clk) disable iff (!rst_n)
      (rise && ce_s) |=> out_shift == ($past(fault_frame_a_sel) ? $past(fault_frame_a_tx)
                                                       : $past(normal_tx));
  endproperty
  a_reload: assert property (p_reload)
    else $error("Output word not reloaded between frames.");

  property p_over;
    @(posedge clk) disable iff (!rst_n)
      (ovr_s && c_mode == motor_ctrl_pkg::stepper_mode)
        |=> step_phase_a == 2'b00 && step_phase_b == 2'b00;
  endproperty
  a_over: assert property (p_over)
    else $error("Stepper outputs active above the supply limit.");

  property p_therm;
    @(posedge clk) disable iff (!rst_n)
      therm_s[0] |=> drv_a_outputs == `BR_OFF;
  endproperty
  a_therm: assert property (p_therm)
    else $error("Driver A stayed on during thermal shutdown.");

  property p_follow_a;
    @(posedge clk) disable iff (!rst_n)
      (!fault[0] && pwm_a)
        |=> drv_a_outputs == ($past(normal_reg[`NB_DIR_A]) ? `BR_REV
                                                          : `BR_FWD);
  endproperty
  a_follow_a: assert property (p_follow_a)
    else $error("Driver A does not follow its PWM and direction.");
endmodule // motor_serial_ctrl

// File: test/host_model.sv
// Host model: free-running serial clock and a frame-level serial master.
`timescale 1ns/1ns
module host_model (
  output logic      sclk,
  output logic      ce_n,
  output logic      mosi,
  input  wire logic miso_o,
  input  wire logic miso_oe
);
  // The serial clock never stops, so converter sampling stays even.
  initial
  begin
    sclk = 1'b0;
    ce_n = 1'b1;
    mosi = 1'b0;
    #3;
    forever #80 sclk = ~sclk;
  end

  // One frame of n rises; data moves on falling edges to give setup time.
  // A full frame leaves enable low, so later rises are ignored there.
  task automatic xfer(input motor_ctrl_pkg::frame_t tx, input int n,
                      output motor_ctrl_pkg::frame_t rx);
    rx = 16'h0000;
    if (!ce_n)
    begin
      @(negedge sclk);
      ce_n = 1'b1;
    end
    @(posedge sclk);
    for (int i = 15; i > 15 - n; i--)
    begin
      @(negedge sclk);
      ce_n = 1'b0;
      rx[i] = miso_oe ? miso_o : ~rx[i];
      mosi = tx[i];
    end
    @(negedge sclk);
    mosi = 1'b0;
    if (n < 16)
      ce_n = 1'b1;
  endtask
endmodule // host_model

// File: test/motor_serial_ctrl_tb.sv
// Self-checking bench for the serial motor driver control block.
`timescale 1ns/1ns
`include "motor_ctrl_defines.svh"
module motor_serial_ctrl_tb;
  logic                   clk;
  logic                   rst_n;
  logic                   wb_cyc;
  logic                   wb_stb;
  logic                   wb_we;
  logic [7:0]             wb_adr;
  logic [31:0]            wb_dat_i;
  logic [31:0]            wb_dat_o;
  logic                   wb_ack;
  logic                   sclk;
  logic                   ce_n;
  logic                   mosi;
  logic                   miso_o;
  logic                   miso_oe;
  logic [3:0]             pwm;
  logic [2:0]             cl_high;
  logic [2:0]             cl_low;
  logic [2:0]             therm_trip;
  logic                   over;
  logic [3:0]             drv_a_outputs;
  logic [3:0]             drv_b_outputs;
  logic                   c_first;
  logic                   c_second;
  logic [1:0]             step_phase_a;
  logic [1:0]             step_phase_b;
  logic [1:0]             gp_low_switch;
  int                     err_total;
  int                     checks_done;
  motor_ctrl_pkg::frame_t rx;

  // Short filter counts keep the fault scenarios brief.
  motor_serial_ctrl #(.DEG_CYC(4), .OFF_CYC(20)) motor_serial_ctrl_i (
    .clk(clk), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_dat_i(wb_dat_i), .wb_sel(4'h3),
    .wb_dat_o(wb_dat_o), .wb_ack(wb_ack), .sclk(sclk), .ce_n(ce_n),
    .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe),
    .drv_a_pwm_in(pwm[0]), .drv_b_pwm_in(pwm[1]),
    .drv_c_pwm_first(pwm[2]), .drv_c_pwm_second(pwm[3]),
    .cl_high(cl_high), .cl_low(cl_low), .therm_trip(therm_trip),
    .supply_over_limit(over), .drv_a_outputs(drv_a_outputs),
    .drv_b_outputs(drv_b_outputs), .drv_c_out_first(c_first),
    .drv_c_out_second(c_second), .step_phase_a(step_phase_a),
    .step_phase_b(step_phase_b), .gp_low_switch(gp_low_switch));

  // The host drives the serial pins; the bench drives everything else.
  host_model host_model_i (
    .sclk(sclk), .ce_n(ce_n), .mosi(mosi),
    .miso_o(miso_o), .miso_oe(miso_oe));

  // Free-running system clock.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // One classic cycle; the request stands until ack is seen at an edge.
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [15:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_i <= {16'h0000, dat};
    @(posedge clk);
    while (wb_ack !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (n >= 20)
    begin
      err_total++;
      report_and_stop();
    end
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] v;
    wb(1'b0, adr, 16'h0000, v);
    chk(v, exp);
  endtask

  task automatic frame(input motor_ctrl_pkg::frame_t tx);
    host_model_i.xfer(tx, 16, rx);
  endtask

  // Pins pass two synchroniser stages and one output register.
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask

  task automatic test_reset();
    repeat (8) @(posedge clk);
    chk(miso_oe, 1'b0);
    chk(drv_a_outputs, `BR_BRAKE);
    chk(drv_b_outputs, `BR_BRAKE);
    chk({c_first, c_second, step_phase_a, step_phase_b}, 6'h00);
    rst_n <= 1'b1;
    rd_chk(`ADR_NORMAL_RX, 32'h0000_0000);
    rd_chk(`ADR_CONFIG_RX, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);
    $display("test_reset done");
  endtask

  task automatic test_link();
    logic [31:0] v;
    wb(1'b1, `ADR_NORMAL_TX, 16'hA5C3, v);
    wb(1'b1, `ADR_FAULT_FRAME_A_TX, 16'h3C5A, v);
    frame(16'hC0E2);
    chk(rx, 16'hA5C3);
    rd_chk(`ADR_NORMAL_RX, 32'h0000_C0E2);
    frame(16'h1230);
    chk(rx, 16'h3C5A);
    rd_chk(`ADR_NORMAL_RX, 32'h0000_1230);
    frame(16'h2001);
    chk(rx, 16'hA5C3);
    rd_chk(`ADR_CONFIG_RX, 32'h0000_2001);
    rd_chk(`ADR_NORMAL_RX, 32'h0000_1230);
    wb(1'b0, `ADR_STATUS, 16'h0000, v);
    chk(v[9], 1'b1);
    $display("test_link done");
  endtask

  // A cut-off frame must leave the normal register as it was.
  task automatic test_short();
    logic [31:0] v;
    host_model_i.xfer(16'hFFFE, 8, rx);
    frame(16'h0001);
    rd_chk(`ADR_NORMAL_RX, 32'h0000_1230);
    rd_chk(`ADR_CONFIG_RX, 32'h0000_0001);
    wb(1'b1, `ADR_NORMAL_RX, 16'hFFFF, v);
    rd_chk(`ADR_NORMAL_RX, 32'h0000_1230);
    $display("test_short done");
  endtask

  task automatic test_stepper();
    // Steady levels stand in for a 20 to 40 kHz PWM, whose period spans
    // thousands of clocks, so each level is one slice of that waveform.
    @(posedge clk);
    pwm <= 4'b0111;
    frame(16'h0028);
    settle();
    chk(drv_a_outputs, `BR_FWD);
    chk(drv_b_outputs, `BR_REV);
    chk({c_first, c_second}, 2'b10);
    chk(step_phase_a, 2'b10);
    chk(step_phase_b, 2'b01);
    chk(gp_low_switch, 2'b00);
    @(posedge clk);
    pwm <= 4'b1110;
    settle();
    chk(drv_a_outputs, `BR_BRAKE);
    chk(step_phase_b, 2'b10);
    @(posedge clk);
    pwm <= 4'b0111;
    frame(16'h002C);
    settle();
    chk(drv_a_outputs, `BR_REV);
    @(posedge clk);
    over <= 1'b1;
    settle();
    chk({step_phase_a, step_phase_b}, 4'h0);
    @(posedge clk);
    over <= 1'b0;
    $display("test_stepper done");
  endtask

  task automatic test_dc();
    frame(16'h2001);
    frame(16'h0080);
    @(posedge clk);
    pwm <= 4'b0100;
    settle();
    chk({c_first, c_second, step_phase_a}, 4'b1001);
    chk(step_phase_b, 2'b00);
    chk(gp_low_switch, 2'b01);
    frame(16'h0090);
    settle();
    chk({c_first, c_second, step_phase_a}, 4'b0110);
    frame(16'h0001);
    $display("test_dc done");
  endtask

  // A glitch must pass; a held detect trips and times out.
  task automatic test_faults();
    frame(16'h0000);
    @(posedge clk);
    pwm <= 4'b0011;
    settle();
    cl_high <= 3'b001;
    repeat (2) @(posedge clk);
    cl_high <= 3'b000;
    repeat (12)
    begin
      @(posedge clk);
      chk(drv_a_outputs, `BR_FWD);
    end
    cl_low <= 3'b001;
    repeat (12) @(posedge clk);
    chk(drv_a_outputs, `BR_OFF);
    cl_low <= 3'b000;
    repeat (8) @(posedge clk);
    chk(drv_a_outputs, `BR_OFF);
    repeat (40) @(posedge clk);
    chk(drv_a_outputs, `BR_FWD);
    therm_trip <= 3'b010;
    settle();
    chk(drv_b_outputs, `BR_OFF);
    chk(drv_a_outputs, `BR_FWD);
    therm_trip <= 3'b000;
    $display("test_faults done");
  endtask

  // Main sequence.
  initial
  begin
    err_total = 0;
    checks_done = 0;
    rst_n = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_dat_i = 32'h0000_0000;
    pwm = 4'h0;
    cl_high = 3'h0;
    cl_low = 3'h0;
    therm_trip = 3'h0;
    over = 1'b0;
    test_reset();
    test_link();
    test_short();
    test_stepper();
    test_dc();
    test_faults();
    report_and_stop();
  end
endmodule // motor_serial_ctrl_tb
